// ---- src/rdp_port.sv ----
`timescale 1ns/100ps
`include "rdp_cfg.svh"

module rdp_port (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // host i/o port access
    input  wire logic [7:0]                   io_addr,
    input  wire logic [7:0]                   io_wdata,
    input  wire logic                         io_wr,
    input  wire logic                         io_rd,
    // host read answer and wait
    output logic      [7:0]                   io_rdata_q,
    output logic                              io_rdata_oe_q,
    output logic                              io_wait_q,
    // setup switches, open reads as 1
    input  wire logic [`RDP_BASE_WIDTH-1:0]   base_sw,
    input  wire logic [`RDP_BOARD_SW_WIDTH-1:0] board_sw_open,
    // indicators, active high
    output logic                              access_led_q,
    output logic                              select_led_q,
    // memory array, board-local address
    output logic      [`RDP_MEM_AW-1:0]       mem_raddr_q,
    input  wire logic [7:0]                   mem_rdata,
    // memory write
    output logic      [`RDP_MEM_AW-1:0]       mem_waddr_q,
    output logic      [7:0]                   mem_wdata_q,
    output logic                              mem_we_q
);

    ////////////////////////////////////////////////////////////////////////
    // switch synchronisers

    logic [`RDP_BASE_WIDTH-1:0]     base_s;
    logic [`RDP_BOARD_SW_WIDTH-1:0] board_closed_s;

    rdp_sync #(
        .WIDTH (`RDP_BASE_WIDTH)
    ) u_base_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (base_sw),
        .sync_q   (base_s)
    );

    // the closed level is synchronised, so the cleared stages name no
    // board and the select light stays dark until the switches settle
    rdp_sync #(
        .WIDTH (`RDP_BOARD_SW_WIDTH)
    ) u_board_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (~board_sw_open),
        .sync_q   (board_closed_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // port decode

    logic       hit;
    logic [1:0] ofs;
    logic       wr_hit;
    logic       rd_hit;
    logic       data_acc;
    logic       wr_data;
    logic       rd_data;
    logic       wr_high;
    logic       wr_low;
    logic       wr_byte;
    logic       go_xfer;
    logic       hang_req;

    // one strobe per cycle, so at most one of wr_data, rd_data, wr_high, wr_low and wr_byte is high
    always_comb begin
        hit      = (io_addr[`RDP_BASE_MSB:`RDP_BASE_LSB] == base_s);
        ofs      = io_addr[1:0];
        wr_hit   = hit && io_wr;
        rd_hit   = hit && io_rd;
        data_acc = (wr_hit || rd_hit) && (ofs == `RDP_OFS_DATA);
        wr_data  = wr_hit && (ofs == `RDP_OFS_DATA);
        rd_data  = rd_hit && (ofs == `RDP_OFS_DATA);
        wr_high  = wr_hit && (ofs == `RDP_OFS_HIGH);
        wr_low   = wr_hit && (ofs == `RDP_OFS_LOW);
        wr_byte  = wr_hit && (ofs == `RDP_OFS_BYTE);
    end

    ////////////////////////////////////////////////////////////////////////
    // address registers

    logic [`RDP_HI_WIDTH-1:0] hi_d;
    logic [`RDP_HI_WIDTH-1:0] hi_q;
    logic [`RDP_LO_WIDTH-1:0] lo_d;
    logic [`RDP_LO_WIDTH-1:0] lo_q;
    logic                     protect;
    logic [2:0]               board_fld;
    logic                     selected;
    logic                     sel_d;

    // bit 7 of the high register has no storage
    always_comb begin
        hi_d = hi_q;
        if (wr_high) begin
            hi_d = io_wdata[`RDP_HI_WIDTH-1:0];
        end
    end

    // protect comes out of reset set, so a host that powers up beside a
    // board on standby power cannot disturb its contents
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_q <= `RDP_HI_RST;
        end else begin
            hi_q <= hi_d;
        end
    end

    always_comb begin
        lo_d = lo_q;
        if (wr_low) begin
            lo_d = io_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_q <= `RDP_LO_RST;
        end else begin
            lo_q <= lo_d;
        end
    end

    // select follows the field being written, so the light changes in
    // the same cycle as the memory address does
    always_comb begin
        protect   = hi_q[`RDP_HI_WP_BIT];
        board_fld = hi_q[`RDP_HI_BOARD_MSB:`RDP_HI_BOARD_LSB];
        selected  = board_closed_s[board_fld];
        sel_d     = board_closed_s[hi_d[`RDP_HI_BOARD_MSB:`RDP_HI_BOARD_LSB]];
    end

    ////////////////////////////////////////////////////////////////////////
    // byte location counter

    logic                       byte_clr;
    logic                       byte_load;
    logic                       byte_inc;
    logic [`RDP_BYTE_WIDTH-1:0] byte_d;
    logic [`RDP_BYTE_WIDTH-1:0] byte_q;

    always_comb begin
        byte_clr  = wr_low;
        // bit 7 of a byte register write is dropped at the counter
        byte_load = wr_byte;
        byte_inc  = go_xfer;
    end

    rdp_byte_ctr u_byte_ctr (
        .clk      (clk),
        .rst_n    (rst_n),
        .clr      (byte_clr),
        .load     (byte_load),
        .load_val (io_wdata[`RDP_BYTE_WIDTH-1:0]),
        .inc      (byte_inc),
        .cnt_d    (byte_d),
        .cnt_q    (byte_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode: a data access to a protected board hangs the host

    rdp_pkg::rdp_mode_t mode_d;
    rdp_pkg::rdp_mode_t mode_q;

    // the hang does not look at the board select: a protected board
    // stalls the host even when it is not the one addressed
    always_comb begin
        hang_req = data_acc && protect;
        // a hung board ignores every data access until reset
        go_xfer  = data_acc && !protect && selected
                   && (mode_q == rdp_pkg::RDP_RUN);
    end

    always_comb begin
        mode_d   = mode_q;
        unique case (mode_q)
            rdp_pkg::RDP_RUN: begin
                if (hang_req) begin
                    mode_d = rdp_pkg::RDP_HUNG;
                end
            end
            rdp_pkg::RDP_HUNG: begin
                mode_d = rdp_pkg::RDP_HUNG;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= rdp_pkg::RDP_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory side

    logic [`RDP_MEM_AW-1:0] raddr_d;
    logic [`RDP_MEM_AW-1:0] waddr_d;
    logic [7:0]             wdata_d;
    logic                   we_d;
    logic [7:0]             rdata_d;
    logic                   rdata_oe_d;

    // read address tracks the next pointer, so memory data is ready
    // in the strobe cycle and the host never waits on a good board
    always_comb begin
        raddr_d = {hi_d[`RDP_HI_BANK_MSB:`RDP_HI_A15_BIT], lo_d, byte_d};
        waddr_d = mem_waddr_q;
        wdata_d = mem_wdata_q;
        we_d    = 1'b0;
        // the write lands at the pointer as it stood before the step
        if (go_xfer && wr_data) begin
            waddr_d = mem_raddr_q;
            wdata_d = io_wdata;
            we_d    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_raddr_q <= '0;
            mem_waddr_q <= '0;
            mem_wdata_q <= 8'h00;
            mem_we_q    <= 1'b0;
        end else begin
            mem_raddr_q <= raddr_d;
            mem_waddr_q <= waddr_d;
            mem_wdata_q <= wdata_d;
            mem_we_q    <= we_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host read data

    // registers 1 to 3 are write only: the bus is left undriven
    always_comb begin
        rdata_d    = io_rdata_q;
        rdata_oe_d = 1'b0;
        if (go_xfer && rd_data) begin
            rdata_d    = mem_rdata;
            rdata_oe_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_rdata_q    <= 8'h00;
            io_rdata_oe_q <= 1'b0;
        end else begin
            io_rdata_q    <= rdata_d;
            io_rdata_oe_q <= rdata_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators and wait

    logic acc_led_d;
    logic sel_led_d;
    logic wait_d;

    // the access light is a one-cycle pulse per performed transfer; a
    // lamp driver has to stretch it to make it visible
    always_comb begin
        acc_led_d = go_xfer;
        sel_led_d = sel_d;
        wait_d    = (mode_d == rdp_pkg::RDP_HUNG);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            access_led_q <= 1'b0;
            select_led_q <= 1'b0;
            io_wait_q    <= 1'b0;
        end else begin
            access_led_q <= acc_led_d;
            select_led_q <= sel_led_d;
            io_wait_q    <= wait_d;
        end
    end

endmodule : rdp_port

// ---- src/rdp_cfg.svh ----
`ifndef RDP_CFG_SVH
`define RDP_CFG_SVH

// port offsets within the block of four, taken from address bits 1:0
`define RDP_OFS_DATA       2'h0
`define RDP_OFS_HIGH       2'h1
`define RDP_OFS_LOW        2'h2
`define RDP_OFS_BYTE       2'h3

// high address register fields
`define RDP_HI_WP_BIT      6
`define RDP_HI_BOARD_MSB   5
`define RDP_HI_BOARD_LSB   3
`define RDP_HI_BANK_MSB    2
`define RDP_HI_BANK_LSB    1
`define RDP_HI_A15_BIT     0
`define RDP_HI_WIDTH       7
`define RDP_LO_WIDTH       8
`define RDP_BYTE_WIDTH     7
`define RDP_MEM_AW         18

// reset values; protect is on so a host power-up cannot alter memory
`define RDP_HI_RST         7'h40
`define RDP_LO_RST         8'h00
`define RDP_BYTE_RST       7'h00

// base switch field: address bits 7:2
`define RDP_BASE_MSB       7
`define RDP_BASE_LSB       2
`define RDP_BASE_WIDTH     6
`define RDP_BOARD_SW_WIDTH 8

`endif

// ---- src/rdp_pkg.sv ----
package rdp_pkg;

    // run: normal port service; hung: data access hit a protected board
    typedef enum logic {
        RDP_RUN,
        RDP_HUNG
    } rdp_mode_t;

endpackage : rdp_pkg

// ---- src/rdp_sync.sv ----
`timescale 1ns/100ps
`include "rdp_cfg.svh"

module rdp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_q
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule : rdp_sync

// ---- src/rdp_byte_ctr.sv ----
`timescale 1ns/100ps
`include "rdp_cfg.svh"

module rdp_byte_ctr (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // control
    input  wire logic                       clr,
    input  wire logic                       load,
    input  wire logic [`RDP_BYTE_WIDTH-1:0] load_val,
    input  wire logic                       inc,
    // count
    output logic      [`RDP_BYTE_WIDTH-1:0] cnt_d,
    output logic      [`RDP_BYTE_WIDTH-1:0] cnt_q
);

    // wraps within the 128 byte page; never carries into the page address
    always_comb begin
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = `RDP_BYTE_RST;
        end else if (load) begin
            cnt_d = load_val;
        end else if (inc) begin
            cnt_d = cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= `RDP_BYTE_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : rdp_byte_ctr

// ---- bench/rdp_port_asserts.sv ----
`timescale 1ns/100ps

module rdp_port_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // host side
    input wire logic [7:0]  io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic        io_rdata_oe_q,
    input wire logic        io_wait_q,
    input wire logic        access_led_q,
    // memory side
    input wire logic [17:0] mem_raddr_q,
    input wire logic [17:0] mem_waddr_q,
    input wire logic        mem_we_q
);
    logic [1:0] ofs;
    assign ofs = io_addr[1:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wait_sticky_a: assert property (io_wait_q |=> io_wait_q)
        else $error("wait released without reset");
    hang_cause_a: assert property ($rose(io_wait_q) |->
        $past(io_wr) || $past(io_rd)) else $error("hang without access");
    hung_quiet_a: assert property (io_wait_q |-> !mem_we_q)
        else $error("memory written while hung");
    we_led_a: assert property (mem_we_q |-> access_led_q)
        else $error("write without access light");
    oe_led_a: assert property (io_rdata_oe_q |-> access_led_q)
        else $error("read without access light");
    led_cause_a: assert property (access_led_q |->
        $past(io_wr) || $past(io_rd)) else $error("stray access light");
    oe_port_a: assert property (io_rdata_oe_q |->
        $past(io_rd) && $past(ofs) == 2'h0) else $error("bad bus drive");
    step_next_a: assert property (mem_we_q |->
        mem_raddr_q[6:0] == mem_waddr_q[6:0] + 7'h01)
        else $error("byte counter did not step");
    write_ptr_a: assert property (mem_we_q |->
        mem_waddr_q == $past(mem_raddr_q)) else $error("bad write address");
    cover property (mem_we_q);
    cover property (io_rdata_oe_q);
    cover property ($rose(io_wait_q));
endmodule : rdp_port_chk

bind rdp_port rdp_port_chk u_chk (.clk, .rst_n, .io_addr, .io_wr, .io_rd,
    .io_rdata_oe_q, .io_wait_q, .access_led_q, .mem_raddr_q, .mem_waddr_q,
    .mem_we_q);

// ---- bench/rdp_host.sv ----
`timescale 1ns/100ps

module rdp_host #(
    parameter logic [7:0] BASE = 8'hd0
) (
    // bus clock
    input  wire logic       clk,
    // port cycles
    output logic      [7:0] io_addr,
    output logic      [7:0] io_wdata,
    output logic            io_wr,
    output logic            io_rd,
    input  wire logic [7:0] io_rdata_q,
    input  wire logic       io_rdata_oe_q
);
    initial begin
        io_addr  = 8'h00;
        io_wdata = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        // released lines must not keep showing the last byte
        io_wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic oe);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        // the bus is driven only in the cycle after the strobe; io_rdata_q holds the byte until the next read
        #1;
        d  = io_rdata_q;
        oe = io_rdata_oe_q;
    endtask : rd
    task automatic set_sector(input logic [5:0] hi, input logic [7:0] lo);
        wr(BASE + 8'h01, {2'b00, hi});
        wr(BASE + 8'h02, lo);
    endtask : set_sector
    task automatic power_down(input logic [5:0] hi);
        wr(BASE + 8'h01, {2'b01, hi});
    endtask : power_down
endmodule : rdp_host

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`include "rdp_cfg.svh"

module tb;
    localparam logic [7:0]  B  = 8'hd0;
    localparam logic [17:0] PG = {2'b11, 1'b0, 8'h05, 7'h00};
    logic        clk, rst_n, io_wr, io_rd, io_rdata_oe_q, io_wait_q;
    logic        access_led_q, select_led_q, mem_we_q, oe_v;
    logic [7:0]  io_addr, io_wdata, io_rdata_q, mem_rdata, mem_wdata_q, rd_v;
    logic [7:0]  board_sw;
    logic [17:0] mem_raddr_q, mem_waddr_q;
    logic [7:0]  mem [0:262143];
    int          fail_count, n_compared, n_we, n_acc;

    rdp_port i_rdp_port (.clk, .rst_n, .io_addr, .io_wdata, .io_wr, .io_rd,
        .io_rdata_q, .io_rdata_oe_q, .io_wait_q, .base_sw(B[7:2]),
        .board_sw_open(board_sw), .access_led_q, .select_led_q, .mem_raddr_q,
        .mem_rdata, .mem_waddr_q, .mem_wdata_q, .mem_we_q);
    rdp_host #(.BASE(B)) u_host (.clk, .io_addr, .io_wdata, .io_wr, .io_rd,
        .io_rdata_q, .io_rdata_oe_q);

    assign mem_rdata = mem[mem_raddr_q];
    always @(posedge clk) begin
        if (mem_we_q) begin
            mem[mem_waddr_q] <= mem_wdata_q;
            n_we++;
        end
        if (access_led_q) begin
            n_acc++;
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // switch synchronisers need a few edges before decode is valid
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic t_select;
        u_host.set_sector(6'h06, 8'h05);
        chk(select_led_q, 1'b1);
        u_host.wr(B + 8'h01, 8'h0e);
        chk(select_led_q, 1'b0);
        // close the board 1 switch: select follows once synchronised
        @(posedge clk);
        board_sw <= 8'hfd;
        repeat (4) @(posedge clk);
        #1;
        chk(select_led_q, 1'b1);
        @(posedge clk);
        board_sw <= 8'hfe;
        repeat (4) @(posedge clk);
        #1;
        chk(select_led_q, 1'b0);
        u_host.wr(B, 8'h11);
        u_host.wr(8'hd4, 8'h22);
        u_host.rd(B + 8'h01, rd_v, oe_v);
        chk(oe_v, 1'b0);
        chk(n_we, 0);
        chk(n_acc, 0);
        $display("select test done");
    endtask : t_select
    task automatic t_write;
        u_host.set_sector(6'h06, 8'h05);
        u_host.wr(B, 8'h80);
        u_host.wr(B, 8'he5);
        @(posedge clk);
        #1;
        chk(mem[PG], 8'h80);
        chk(mem[PG + 18'h1], 8'he5);
        chk(mem_raddr_q, PG + 18'h2);
        u_host.wr(B + 8'h03, 8'hff);
        u_host.wr(B, 8'h5a);
        chk(mem_raddr_q, PG);
        u_host.rd(B, rd_v, oe_v);
        chk({oe_v, rd_v}, 9'h180);
        chk(mem[PG + 18'h7f], 8'h5a);
        $display("write test done");
    endtask : t_write
    task automatic t_protect;
        u_host.power_down(6'h06);
        u_host.wr(B + 8'h02, 8'h07);
        u_host.wr(B, 8'h33);
        chk(io_wait_q, 1'b1);
        u_host.rd(B, rd_v, oe_v);
        chk(oe_v, 1'b0);
        chk(n_we, 3);
        chk(n_acc, 4);
        do_reset();
        chk(io_wait_q, 1'b0);
        u_host.rd(B, rd_v, oe_v);
        chk({oe_v, io_wait_q}, 2'b01);
        $display("protect test done");
    endtask : t_protect
    task automatic wrap_up;
        $display("compared %0d, wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    initial begin
        fail_count = 0;
        n_compared = 0;
        n_we = 0;
        n_acc = 0;
        board_sw = 8'hfe;
        rst_n = 1'b0;
        do_reset();
        t_select();
        t_write();
        t_protect();
        wrap_up();
    end
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
endmodule : tb
